// ==== common/prf_pkg.sv ====
// Purpose: Constants and carriers for the profile request frame builder
// Assumes: One 200 MHz clock, bytes arrive one per valid cycle
// Notes:   Field index lists below; frame offsets count from the type byte
package prf_pkg;

	// Framing bytes
	localparam logic [7:0]  PRF_DELIM      = 8'h7E;
	localparam logic [7:0]  PRF_TYPE_TX    = 8'h11;
	localparam logic [7:0]  PRF_TYPE_EXRX  = 8'h91;
	localparam logic [7:0]  PRF_CSUM_BASE  = 8'hFF;
	localparam logic [7:0]  PRF_ENERGY_JAM = 8'hFF;

	// Cluster identifiers
	localparam logic [15:0] PRF_CL_NWK     = 16'h0000;
	localparam logic [15:0] PRF_CL_IEEE    = 16'h0001;
	localparam logic [15:0] PRF_CL_NODE    = 16'h0002;
	localparam logic [15:0] PRF_CL_NOTIFY  = 16'h8038;

	// Broadcast addresses
	localparam logic [63:0] PRF_BCAST64    = 64'h0000_0000_0000_FFFF;
	localparam logic [15:0] PRF_BCAST16    = 16'hFFFE;

	// Transmit-request field indices
	localparam logic [15:0] PRF_TX_FID     = 16'h0001;
	localparam logic [15:0] PRF_TX_A64_LO  = 16'h0002;
	localparam logic [15:0] PRF_TX_A64_HI  = 16'h0009;
	localparam logic [15:0] PRF_TX_A16_HI  = 16'h000A;
	localparam logic [15:0] PRF_TX_A16_LO  = 16'h000B;
	localparam logic [15:0] PRF_TX_CL_HI   = 16'h000E;
	localparam logic [15:0] PRF_TX_CL_LO   = 16'h000F;
	localparam logic [15:0] PRF_TX_PAY     = 16'h0014;

	// Explicit-receive field indices
	localparam logic [15:0] PRF_RX_CL_HI   = 16'h000D;
	localparam logic [15:0] PRF_RX_CL_LO   = 16'h000E;
	localparam logic [15:0] PRF_RX_PAY     = 16'h0012;

	// Notify payload offsets
	localparam logic [15:0] PRF_NP_SEQ     = 16'h0000;
	localparam logic [15:0] PRF_NP_STATUS  = 16'h0001;
	localparam logic [15:0] PRF_NP_MASK0   = 16'h0002;
	localparam logic [15:0] PRF_NP_MASK3   = 16'h0005;
	localparam logic [15:0] PRF_NP_TX0     = 16'h0006;
	localparam logic [15:0] PRF_NP_TX1     = 16'h0007;
	localparam logic [15:0] PRF_NP_FAIL0   = 16'h0008;
	localparam logic [15:0] PRF_NP_FAIL1   = 16'h0009;
	localparam logic [15:0] PRF_NP_COUNT   = 16'h000A;
	localparam logic [5:0]  PRF_NO_CHAN    = 6'h20;

	// Decoded notify payload
	typedef struct packed {
		logic [7:0]  seq;
		logic [7:0]  status;
		logic [31:0] mask;
		logic [15:0] total_tx;
		logic [15:0] tx_fail;
		logic [7:0]  rec_count;
	} prf_notify_t;

	// Decoded host request
	typedef struct packed {
		logic [7:0]  frame_id;
		logic [15:0] cluster;
		logic [15:0] dst16;
		logic [7:0]  seq;
		logic        bcast;
	} prf_req_t;

	// One energy record
	typedef struct packed {
		logic [7:0]  level;
		logic [5:0]  chan;
		logic        jam;
	} prf_energy_t;

endpackage

// ==== logic/prf_frame_builder.sv ====
// Purpose: Frame receiver that checks framing and decodes requests/notifies
// Assumes: Synchronous reset, input bytes synchronous to i_clk
// Notes:   Energy records stream out before the checksum is known
`timescale 1ns/1ps
module prf_frame_builder (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	// Byte stream in
	input  wire logic                 i_rx_valid,
	input  wire logic [7:0]           i_rx_byte,
	// Frame status
	output logic                      o_frame_done,
	output logic                      o_csum_err,
	output logic [7:0]                o_frame_type,
	// Host request decode
	output logic                      o_req_valid,
	output prf_pkg::prf_req_t         o_req,
	// Notify decode
	output logic                      o_notify_valid,
	output prf_pkg::prf_notify_t      o_notify,
	output logic                      o_seq_match,
	output logic                      o_count_mismatch,
	// Energy records
	output logic                      o_energy_valid,
	output prf_pkg::prf_energy_t      o_energy
);
	import prf_pkg::*;

	typedef enum logic [2:0] {
		PRF_IDLE, PRF_LEN_HI, PRF_LEN_LO, PRF_BODY, PRF_CSUM
	} prf_state_t;

	prf_state_t   state, next_state;
	logic [15:0]  len, next_len;
	logic [15:0]  idx, next_idx;
	logic [7:0]   sum, next_sum;
	logic [7:0]   ftype, next_ftype;
	logic [15:0]  cluster, next_cluster;
	logic [63:0]  addr64, next_addr64;
	prf_req_t     sh_req, next_sh_req;
	prf_notify_t  sh_ntf, next_sh_ntf;
	logic [15:0]  ecnt, next_ecnt;
	logic [5:0]   cptr, next_cptr;
	logic         next_frame_done, next_csum_err, next_req_valid;
	logic         next_notify_valid, next_seq_match, next_count_mismatch;
	logic         next_energy_valid;
	logic [7:0]   next_frame_type;
	prf_req_t     next_req;
	prf_notify_t  next_notify;
	prf_energy_t  next_energy;
	logic [15:0]  p;
	logic [5:0]   ch;
	logic         good;

	// Lowest set mask bit at or above a start channel
	function automatic logic [5:0] first_set(input logic [31:0] m,
		input logic [5:0] from);
		logic [5:0] r;
		r = PRF_NO_CHAN;
		for (int k = 31; k >= 0; k--) begin
			if (6'(k) >= from && m[k]) begin
				r = 6'(k);
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for framing and decode
	always_comb begin
		next_state          = state;
		next_len            = len;
		next_idx            = idx;
		next_sum            = sum;
		next_ftype          = ftype;
		next_cluster        = cluster;
		next_addr64         = addr64;
		next_sh_req         = sh_req;
		next_sh_ntf         = sh_ntf;
		next_ecnt           = ecnt;
		next_cptr           = cptr;
		next_frame_done     = 1'b0;
		next_csum_err       = 1'b0;
		next_req_valid      = 1'b0;
		next_notify_valid   = 1'b0;
		next_energy_valid   = 1'b0;
		next_frame_type     = o_frame_type;
		next_req            = o_req;
		next_notify         = o_notify;
		next_seq_match      = o_seq_match;
		next_count_mismatch = o_count_mismatch;
		next_energy         = o_energy;
		p                   = idx - PRF_RX_PAY;
		ch                  = first_set(sh_ntf.mask, cptr);
		good                = (sum + i_rx_byte) == PRF_CSUM_BASE;
		if (i_rx_valid) begin
			unique case (state)
				PRF_IDLE: begin
					if (i_rx_byte == PRF_DELIM) begin
						next_state = PRF_LEN_HI;
					end
				end
				PRF_LEN_HI: begin
					next_len   = {i_rx_byte, 8'h00};
					next_state = PRF_LEN_LO;
				end
				PRF_LEN_LO: begin
					next_len    = {len[15:8], i_rx_byte};
					next_idx    = 16'h0000;
					next_sum    = 8'h00;
					next_ftype  = 8'h00;
					next_cluster = 16'h0000;
					next_sh_ntf = '0;
					next_sh_req = '0;
					next_ecnt   = 16'h0000;
					next_cptr   = 6'h00;
					next_state  = ({len[15:8], i_rx_byte} == 16'h0000) ?
						PRF_CSUM : PRF_BODY;
				end
				PRF_BODY: begin
					next_sum = sum + i_rx_byte;
					next_idx = idx + 16'h0001;
					if (idx == len - 16'h0001) begin
						next_state = PRF_CSUM;
					end
					if (idx == 16'h0000) begin
						next_ftype = i_rx_byte;
					end
					if (ftype == PRF_TYPE_TX) begin
						if (idx == PRF_TX_FID) begin
							next_sh_req.frame_id = i_rx_byte;
						end
						if (idx >= PRF_TX_A64_LO && idx <= PRF_TX_A64_HI) begin
							next_addr64 = {addr64[55:0], i_rx_byte};
						end
						if (idx == PRF_TX_A16_HI) begin
							next_sh_req.dst16[15:8] = i_rx_byte;
						end
						if (idx == PRF_TX_A16_LO) begin
							next_sh_req.dst16[7:0] = i_rx_byte;
						end
						if (idx == PRF_TX_CL_HI) begin
							next_sh_req.cluster[15:8] = i_rx_byte;
						end
						if (idx == PRF_TX_CL_LO) begin
							next_sh_req.cluster[7:0] = i_rx_byte;
						end
						if (idx == PRF_TX_PAY) begin
							next_sh_req.seq = i_rx_byte;
						end
					end
					if (ftype == PRF_TYPE_EXRX) begin
						if (idx == PRF_RX_CL_HI) begin
							next_cluster[15:8] = i_rx_byte;
						end
						if (idx == PRF_RX_CL_LO) begin
							next_cluster[7:0] = i_rx_byte;
						end
					end
					if (ftype == PRF_TYPE_EXRX && cluster == PRF_CL_NOTIFY &&
						idx >= PRF_RX_PAY) begin
						if (p == PRF_NP_SEQ) begin
							next_sh_ntf.seq = i_rx_byte;
						end else if (p == PRF_NP_STATUS) begin
							next_sh_ntf.status = i_rx_byte;
						end else if (p <= PRF_NP_MASK3) begin
							next_sh_ntf.mask = {i_rx_byte, sh_ntf.mask[31:8]};
						end else if (p == PRF_NP_TX0) begin
							next_sh_ntf.total_tx[7:0] = i_rx_byte;
						end else if (p == PRF_NP_TX1) begin
							next_sh_ntf.total_tx[15:8] = i_rx_byte;
						end else if (p == PRF_NP_FAIL0) begin
							next_sh_ntf.tx_fail[7:0] = i_rx_byte;
						end else if (p == PRF_NP_FAIL1) begin
							next_sh_ntf.tx_fail[15:8] = i_rx_byte;
						end else if (p == PRF_NP_COUNT) begin
							next_sh_ntf.rec_count = i_rx_byte;
						end else begin
							next_energy_valid = 1'b1;
							next_energy.level = i_rx_byte;
							next_energy.jam   = (i_rx_byte == PRF_ENERGY_JAM);
							next_energy.chan  = ch;
							next_cptr = (ch == PRF_NO_CHAN) ? ch : ch + 6'h01;
							next_ecnt = ecnt + 16'h0001;
						end
					end
				end
				PRF_CSUM: begin
					next_state      = PRF_IDLE;
					next_frame_done = 1'b1;
					next_csum_err   = !good;
					next_frame_type = ftype;
					if (good && ftype == PRF_TYPE_TX) begin
						next_req_valid = 1'b1;
						next_req       = sh_req;
						next_req.bcast = (addr64 == PRF_BCAST64) &&
							(sh_req.dst16 == PRF_BCAST16);
					end
					if (good && ftype == PRF_TYPE_EXRX &&
						cluster == PRF_CL_NOTIFY) begin
						next_notify_valid   = 1'b1;
						next_notify         = sh_ntf;
						next_seq_match      = (sh_ntf.seq == o_req.seq);
						next_count_mismatch = (ecnt != {8'h00, sh_ntf.rec_count});
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state            <= PRF_IDLE;
			len              <= 16'h0000;
			idx              <= 16'h0000;
			sum              <= 8'h00;
			ftype            <= 8'h00;
			cluster          <= 16'h0000;
			addr64           <= 64'h0;
			sh_req           <= '0;
			sh_ntf           <= '0;
			ecnt             <= 16'h0000;
			cptr             <= 6'h00;
			o_frame_done     <= 1'b0;
			o_csum_err       <= 1'b0;
			o_frame_type     <= 8'h00;
			o_req_valid      <= 1'b0;
			o_req            <= '0;
			o_notify_valid   <= 1'b0;
			o_notify         <= '0;
			o_seq_match      <= 1'b0;
			o_count_mismatch <= 1'b0;
			o_energy_valid   <= 1'b0;
			o_energy         <= '0;
		end else begin
			state            <= next_state;
			len              <= next_len;
			idx              <= next_idx;
			sum              <= next_sum;
			ftype            <= next_ftype;
			cluster          <= next_cluster;
			addr64           <= next_addr64;
			sh_req           <= next_sh_req;
			sh_ntf           <= next_sh_ntf;
			ecnt             <= next_ecnt;
			cptr             <= next_cptr;
			o_frame_done     <= next_frame_done;
			o_csum_err       <= next_csum_err;
			o_frame_type     <= next_frame_type;
			o_req_valid      <= next_req_valid;
			o_req            <= next_req;
			o_notify_valid   <= next_notify_valid;
			o_notify         <= next_notify;
			o_seq_match      <= next_seq_match;
			o_count_mismatch <= next_count_mismatch;
			o_energy_valid   <= next_energy_valid;
			o_energy         <= next_energy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [15:0] h_epulses;
	always_ff @(posedge i_clk) begin
		if (!i_rstn || (state == PRF_LEN_LO && i_rx_valid)) begin
			h_epulses <= 16'h0000;
		end else if (o_energy_valid) begin
			h_epulses <= h_epulses + 16'h0001;
		end
	end

	sequence s_delim;
		state == PRF_IDLE && i_rx_valid && i_rx_byte == PRF_DELIM;
	endsequence
	sequence s_last_body;
		state == PRF_BODY && i_rx_valid && idx == len - 16'h0001;
	endsequence
	sequence s_csum_take;
		state == PRF_CSUM && i_rx_valid;
	endsequence

	// Every check samples on the one clock and rests during reset
	default clocking prf_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	delim_start_a: assert property (s_delim |=> state == PRF_LEN_HI)
		else $error("delimiter did not start a frame");
	len_end_a: assert property (s_last_body |=> state == PRF_CSUM)
		else $error("frame did not end after length bytes");
	csum_done_a: assert property (s_csum_take |=> o_frame_done)
		else $error("checksum byte did not end the frame");
	csum_bad_a: assert property (
		(state == PRF_CSUM && i_rx_valid && !good) |=>
		o_csum_err && !o_notify_valid && !o_req_valid)
		else $error("bad checksum not flagged");
	notify_gate_a: assert property (o_notify_valid |-> o_frame_done &&
		!o_csum_err && o_frame_type == PRF_TYPE_EXRX)
		else $error("notify published on wrong frame");
	energy_jam_a: assert property (o_energy_valid |->
		o_energy.level == $past(i_rx_byte) &&
		o_energy.jam == ($past(i_rx_byte) == PRF_ENERGY_JAM))
		else $error("energy byte or interference flag wrong");
	chan_mask_a: assert property (
		o_energy_valid && o_energy.chan != PRF_NO_CHAN |->
		sh_ntf.mask[o_energy.chan[4:0]])
		else $error("energy channel not in mask");
	seq_match_a: assert property (o_notify_valid |->
		o_seq_match == (o_notify.seq == $past(o_req.seq)))
		else $error("sequence match wrong");
	count_chk_a: assert property (o_notify_valid |->
		o_count_mismatch == (h_epulses != {8'h00, o_notify.rec_count}))
		else $error("record count mismatch wrong");

endmodule // prf_frame_builder

// ==== test/prf_host_model.sv ====
// Purpose: Host controller model that frames bytes for the receiver
// Assumes: Bytes change just after the rising edge of i_clk
// Notes:   Idle cycles show an inverted byte so stale data never repeats
`timescale 1ns/1ps
module prf_host_model (
	// Clock
	input  wire logic       i_clk,
	// Byte stream out
	output logic            o_valid,
	output logic [7:0]      o_byte
);
	import prf_pkg::*;

	logic [7:0]  body[$];
	logic [7:0]  pay[$];
	int          gap_max;

	// Quiet line at time zero
	initial begin
		o_valid = 1'b0;
		o_byte  = 8'h00;
		gap_max = 0;
	end

	// One byte, after up to gap_max idle cycles
	task automatic put(input logic [7:0] b);
		int g;
		g = (gap_max > 0) ? $urandom_range(gap_max) : 0;
		repeat (g) begin
			idle();
		end
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_byte  <= b;
	endtask

	// Release the line
	task automatic idle();
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_byte  <= ~o_byte;
	endtask

	// addresses, endpoints, cluster, profile MSB first
	task automatic head(input logic [63:0] a64, input logic [15:0] a16,
		input logic [15:0] cl);
		for (int i = 7; i >= 0; i--) begin
			body.push_back(a64[i*8 +: 8]);
		end
		body = {body, a16[15:8], a16[7:0], 8'h00, 8'h00, cl[15:8], cl[7:0]};
		body = {body, 8'h00, 8'h00};
	endtask

	// transmit request, zero radius and options
	task automatic tx_req(input logic [7:0] fid, input logic [63:0] a64,
		input logic [15:0] a16, input logic [15:0] cl);
		body = {PRF_TYPE_TX, fid};
		head(a64, a16, cl);
		body = {body, 8'h00, 8'h00, pay};
		pay.delete();
	endtask

	// Explicit receive frame as a remote node would return it
	task automatic rx_frame(input logic [63:0] a64, input logic [15:0] a16,
		input logic [15:0] cl);
		body = {PRF_TYPE_EXRX};
		head(a64, a16, cl);
		body = {body, 8'h01, pay};
		pay.delete();
	endtask

	// delimiter, length MSB first, body, checksum
	task automatic send(input logic bad);
		logic [7:0] sum;
		int         n;
		sum = 8'h00;
		n = body.size();
		put(PRF_DELIM);
		put(n[15:8]);
		put(n[7:0]);
		foreach (body[i]) begin
			put(body[i]);
			sum += body[i];
		end
		put((PRF_CSUM_BASE - sum) ^ {7'h00, bad});
		idle();
		body.delete();
	endtask
endmodule // prf_host_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the profile frame receiver
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes:   Expected results are queued before each frame is sent
`timescale 1ns/1ps
module tb_top;
	import prf_pkg::*;

	logic            clk;
	logic            rstn;
	logic            rx_valid;
	logic [7:0]      rx_byte;
	logic            frame_done;
	logic            csum_err;
	logic [7:0]      frame_type;
	logic            req_valid;
	prf_req_t        req;
	logic            notify_valid;
	prf_notify_t     notify;
	logic            seq_match;
	logic            count_mismatch;
	logic            energy_valid;
	prf_energy_t     energy;
	logic [8:0]      done_q[$];
	prf_req_t        req_q[$];
	logic [89:0]     ntf_q[$];
	prf_energy_t     en_q[$];
	logic [7:0]      last_seq;
	int              fail_count;
	int              samples_checked;

	prf_frame_builder i_dut (
		.i_clk            (clk),
		.i_rstn           (rstn),
		.i_rx_valid       (rx_valid),
		.i_rx_byte        (rx_byte),
		.o_frame_done     (frame_done),
		.o_csum_err       (csum_err),
		.o_frame_type     (frame_type),
		.o_req_valid      (req_valid),
		.o_req            (req),
		.o_notify_valid   (notify_valid),
		.o_notify         (notify),
		.o_seq_match      (seq_match),
		.o_count_mismatch (count_mismatch),
		.o_energy_valid   (energy_valid),
		.o_energy         (energy)
	);

	prf_host_model i_host (
		.i_clk   (clk),
		.o_valid (rx_valid),
		.o_byte  (rx_byte)
	);

	// Clock
	always #2.5 clk = ~clk;

	// Compare value seen with value expected
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A result that nobody asked for
	task automatic stray(input string what);
		fail_count++;
		$display("unexpected at %0t: stray %s", $time, what);
	endtask

	// Take the oldest note whenever a result appears
	always @(negedge clk) begin
		if (rstn === 1'b1) begin
			if (frame_done === 1'b1 && done_q.size() != 0)
				check({csum_err, frame_type}, done_q.pop_front());
			else if (frame_done !== 1'b0)
				stray("frame end");
			if (req_valid === 1'b1 && req_q.size() != 0)
				check(req, req_q.pop_front());
			else if (req_valid !== 1'b0)
				stray("request");
			if (energy_valid === 1'b1 && en_q.size() != 0)
				check(energy, en_q.pop_front());
			else if (energy_valid !== 1'b0)
				stray("energy");
			if (notify_valid === 1'b1 && ntf_q.size() != 0)
				check({notify, seq_match, count_mismatch}, ntf_q.pop_front());
			else if (notify_valid !== 1'b0)
				stray("notify");
		end
	end

	// Payload helpers
	task automatic pp(input logic [7:0] b);
		i_host.pay.push_back(b);
	endtask

	task automatic pn(input logic [87:0] v);
		for (int i = 10; i >= 0; i--) begin
			pp(v[i*8 +: 8]);
		end
	endtask

	task automatic pe(input int n, input int jam_at);
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			r = $urandom;
			pp((i == jam_at) ? PRF_ENERGY_JAM : r[7:0]);
		end
	endtask

	// Note the request decode, then send the frame
	task automatic req_frame(input logic [7:0] fid, input logic [63:0] a64,
		input logic [15:0] a16, input logic [15:0] cl, input logic bad);
		prf_req_t r;
		r.frame_id = fid;
		r.cluster  = cl;
		r.dst16    = a16;
		r.seq      = i_host.pay[0];
		r.bcast    = (a64 === PRF_BCAST64) && (a16 === PRF_BCAST16);
		done_q.push_back({bad, PRF_TYPE_TX});
		if (!bad) begin
			req_q.push_back(r);
			last_seq = r.seq;
		end
		i_host.tx_req(fid, a64, a16, cl);
		i_host.send(bad);
	endtask

	// Note the notify decode and energy records, then send
	task automatic ntf_frame(input logic [15:0] cl);
		logic [7:0]  p[$];
		prf_notify_t n;
		prf_energy_t e;
		int          ch;
		p = i_host.pay;
		ch = 0;
		// mask and counters arrive LSB first
		n = {p[0], p[1], p[5], p[4], p[3], p[2], p[7], p[6], p[9], p[8], p[10]};
		done_q.push_back({1'b0, PRF_TYPE_EXRX});
		// only the notify cluster is decoded, bit n is channel n
		if (cl === PRF_CL_NOTIFY) begin
			for (int k = 11; k < p.size(); k++) begin
				while (ch < 32 && !n.mask[ch])
					ch++;
				e.level = p[k];
				e.chan  = (ch > 31) ? PRF_NO_CHAN : ch[5:0];
				e.jam   = (p[k] === PRF_ENERGY_JAM);
				en_q.push_back(e);
				ch++;
			end
			// energy byte count against record count
			ntf_q.push_back({n, p[0] === last_seq, p.size() - 11 != p[10]});
		end
		i_host.rx_frame(64'h0123_4567_89AB_CDEF, 16'h06FC, cl);
		i_host.send(1'b0);
	endtask

	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Wait, bounded, until every note has been matched
	task automatic end_test(input string name);
		int n;
		n = 0;
		while ((done_q.size() + req_q.size() + ntf_q.size() + en_q.size()) > 0
			&& n < 100) begin
			@(posedge clk);
			n++;
		end
		if ((done_q.size() + req_q.size() + ntf_q.size() + en_q.size()) > 0) begin
			fail_count++;
			$display("unexpected at %0t: %s results missing", $time, name);
			stop_test();
		end else
			$display("test %s done", name);
	endtask

	// Main sequence
	initial begin
		logic [63:0] tgt;
		logic [31:0] rnd;
		clk = 1'b0;
		rstn = 1'b0;
		last_seq = 8'h00;
		fail_count = 0;
		samples_checked = 0;
		void'($urandom(32'hdf9d));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		// junk in idle, then a broadcast network-address request
		i_host.put(8'h55);
		i_host.put(8'hA7);
		tgt = {$urandom, $urandom};
		rnd = $urandom;
		// sequence, target LSB first, type 0x01, start index
		pp(rnd[7:0]);
		for (int i = 0; i < 8; i++) begin
			pp(tgt[i*8 +: 8]);
		end
		pp(8'h01);
		pp(8'h00);
		req_frame(8'h00, PRF_BCAST64, PRF_BCAST16, PRF_CL_NWK, 1'b0);
		end_test("nwk");
		// unicast 64-bit address request with idle gaps
		i_host.gap_max = 3;
		rnd = $urandom;
		pn({rnd[7:0], rnd[15:8], rnd[23:16], 64'h0});
		repeat (8) void'(i_host.pay.pop_back());
		req_frame(rnd[31:24] | 8'h01, tgt, rnd[23:8], PRF_CL_IEEE, 1'b0);
		end_test("ieee");
		// node descriptor with delimiter value in the payload
		i_host.gap_max = 0;
		rnd = $urandom;
		pp(rnd[7:0]);
		pp(8'h31);
		pp(8'h7E);
		req_frame(8'h07, PRF_BCAST64, PRF_BCAST16, PRF_CL_NODE, 1'b0);
		// corrupted checksum straight after must be refused
		pp(8'hEE);
		req_frame(8'h08, tgt, 16'h1234, PRF_CL_NWK, 1'b1);
		end_test("node_bad");
		// notify with matching sequence, all 16 channels
		pn({last_seq, 80'h00_00F8FF07_1D00_0000_10});
		pe(16, 3);
		ntf_frame(PRF_CL_NOTIFY);
		end_test("notify");
		// wrong sequence, count 5 but only 3 records, gaps
		i_host.gap_max = 2;
		rnd = $urandom;
		pn({~last_seq, 8'h5A, 32'h01000080, rnd, 8'h05});
		pe(3, 1);
		ntf_frame(PRF_CL_NOTIFY);
		end_test("short");
		// another cluster is framed but not decoded
		pn({rnd, tgt[31:0], 24'hFFFFFF});
		ntf_frame(16'h8034);
		end_test("other");
		// empty body goes straight to checksum, no type byte
		done_q.push_back(9'h000);
		i_host.send(1'b0);
		end_test("empty");
		// Reset in mid frame, then a clean request
		i_host.put(PRF_DELIM);
		i_host.put(8'h00);
		i_host.idle();
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		pp(8'h42);
		req_frame(8'h00, tgt, 16'h0001, PRF_CL_NODE, 1'b0);
		end_test("reset");
		stop_test();
	end
endmodule // tb_top
